// ===== hdl/eod_regs.svh
// constants for the extended opcode decoder with breakpoint support
//
// What this block does
// - break flag clear: jump-zero is a 3-cycle no-op that may deschedule
// - opcode B3 (2BF3) sets the break flag in 1 cycle
// - opcode B2 (2BF2) clears the break flag in 1 cycle
// - opcode B4 (2BF4) pushes the break flag state in 2 cycles
// - break flag set: jump-zero swaps pointers with the pair above memstart
// - a swap never deschedules and leaves the stack registers untouched
// - break-enabled jump-zero takes 11 cycles high priority, 13 low priority
// - opcode B1 (2BF1) is an explicit break: 9 cycles high, 11 low
// - opcode 08 (F8) multiplies: b+4 cycles for A positive, m+5 negative
// - 5A (25FA) duplicates the top entry, 79 (27F9) pops, 1 cycle each
// - opcode 74 (27F4) computes a CRC over a word in 35 cycles
// - opcode 75 (27F5) computes a CRC over a byte in 11 cycles
// - opcode 76 (27F6) counts set bits of a word in b+2 cycles
// - opcode 77 (27F7) reverses all bits of a word in 36 cycles
// - opcode 78 (27F8) reverses the low n bits of a word in n+4 cycles
// - opcode 7E (27FE) pushes the memstart address in 1 cycle
// - opcodes 7A/7B disable high/low priority timer interrupts in 1 cycle
// - opcodes 7C/7D enable high/low priority timer interrupts in 6 cycles
// - core clock is the 5 MHz input times the multiplier, 4.0 here
// - opcode 17C pushes the product identity number
`ifndef EOD_REGS_SVH
`define EOD_REGS_SVH

// ----------------------------------------
// byte format
// ----------------------------------------
`define EOD_NIB_JUMP      4'h0
`define EOD_NIB_PREFIX    4'h2
`define EOD_NIB_OPERATE   4'hf

// ----------------------------------------
// secondary operation codes
// ----------------------------------------
`define EOD_OP_PROD       16'h0008
`define EOD_OP_DUP        16'h005a
`define EOD_OP_POP        16'h0079
`define EOD_OP_CRCWORD    16'h0074
`define EOD_OP_CRCBYTE    16'h0075
`define EOD_OP_BITCNT     16'h0076
`define EOD_OP_REVWORD    16'h0077
`define EOD_OP_REVNBITS   16'h0078
`define EOD_OP_TMR_DIS_HI 16'h007a
`define EOD_OP_TMR_DIS_LO 16'h007b
`define EOD_OP_TMR_EN_HI  16'h007c
`define EOD_OP_TMR_EN_LO  16'h007d
`define EOD_OP_MEMSTART   16'h007e
`define EOD_OP_BREAK      16'h00b1
`define EOD_OP_BRK_CLR    16'h00b2
`define EOD_OP_BRK_SET    16'h00b3
`define EOD_OP_BRK_QUERY  16'h00b4
`define EOD_OP_DEVID      16'h017c

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define EOD_CYC_J0_PLAIN  6'd3
`define EOD_CYC_J0_HI     6'd11
`define EOD_CYC_J0_LO     6'd13
`define EOD_CYC_BRK_HI    6'd9
`define EOD_CYC_BRK_LO    6'd11
`define EOD_CYC_ONE       6'd1
`define EOD_CYC_QUERY     6'd2
`define EOD_CYC_PROD_POS  6'd4
`define EOD_CYC_PROD_NEG  6'd5
`define EOD_CYC_CRCWORD   6'd35
`define EOD_CYC_CRCBYTE   6'd11
`define EOD_CYC_BITCNT    6'd2
`define EOD_CYC_REVWORD   6'd36
`define EOD_CYC_REVNBITS  6'd4
`define EOD_CYC_TMR_EN    6'd6

// ----------------------------------------
// clock and fixed values
// ----------------------------------------
`define EOD_CLKIN_KHZ     5000
`define EOD_MULT_X10      40
`define EOD_CORE_KHZ      ((`EOD_CLKIN_KHZ * `EOD_MULT_X10) / 10)
`define EOD_MEMSTART      16'h0048
`define EOD_DEVICE_ID     16'h0007 // arbitrary neutral value
`define EOD_SAVE_IPTR_OFS 16'h0002
`define EOD_SAVE_WPTR_OFS 16'h0004
`define EOD_IPTR_RST      16'h0000
`define EOD_WPTR_RST      16'h0100
`define EOD_WORD_ZERO     16'h0000
`define EOD_WORD_TRUE     16'h0001

`endif

// ===== hdl/eod_pkg.sv
// types shared by the extended opcode decoder
package eod_pkg;

    // swap sequence, gray coded from idle to wait; the return from wait to idle changes all three bits
    typedef enum logic [2:0] {
        EOD_ST_IDLE = 3'b000,
        EOD_ST_RD_I = 3'b001,
        EOD_ST_RD_W = 3'b011,
        EOD_ST_WR_I = 3'b010,
        EOD_ST_WR_W = 3'b110,
        EOD_ST_WAIT = 3'b111
    } eod_state_t;

    typedef logic [15:0] eod_word_t;

endpackage

// ===== hdl/eod_cycle_timer.sv
// holds the decoder busy for the cycle count of an instruction
`timescale 1ns/100ps
module eod_cycle_timer (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // load
    input  wire logic       load,
    input  wire logic [5:0] cycles,
    // status
    output logic      [5:0] remain,
    output logic            busy
);
    logic [5:0] cnt_r;

    // an instruction of n cycles holds the decoder for n-1 cycles after acceptance
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= 6'h00;
        end else if (load) begin
            cnt_r <= cycles - 6'd1;
        end else if (cnt_r != 6'h00) begin
            cnt_r <= cnt_r - 6'd1;
        end
    end

    assign remain = cnt_r;
    assign busy   = (cnt_r != 6'h00);
endmodule

// ===== hdl/eod_bit_unit.sv
// combinational bit operations: crc, bit count, reversal, significance
`timescale 1ns/100ps
module eod_bit_unit
    import eod_pkg::*;
(
    // operands
    input  eod_word_t  a,
    input  eod_word_t  b,
    input  eod_word_t  c,
    // results
    output eod_word_t  cnt_sum,
    output eod_word_t  rev_word,
    output eod_word_t  rev_nbits,
    output eod_word_t  crc_word,
    output eod_word_t  crc_byte,
    output logic [4:0] sig_a,
    output logic [4:0] sig_neg_a
);
    // crc: shift data in msb first, fold in generator c on carry out
    function automatic eod_word_t crc_step(eod_word_t crc, eod_word_t d,
                                           eod_word_t gen, int nbits);
        eod_word_t r;
        logic      fb;
        r = crc;
        for (int i = 15; i >= 0; i--) begin
            if (i >= 16 - nbits) begin
                fb = r[15];
                r  = {r[14:0], d[i]};
                if (fb) begin
                    r = r ^ gen;
                end
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] sig_bits(eod_word_t v);
        logic [4:0] n;
        n = 5'd0;
        for (int i = 0; i < 16; i++) begin
            if (v[i]) begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction

    always_comb begin
        eod_word_t rv;
        eod_word_t pc;
        rv = '0;
        pc = '0;
        for (int i = 0; i < 16; i++) begin
            rv[i] = a[15-i];
            pc    = pc + 16'(a[i]);
        end
        rev_word  = rv;
        cnt_sum   = pc + b;
        rev_nbits = (a >= 16'd16) ? rv : ((a == 16'd0) ? '0 : (rv >> (16 - a[3:0])));
    end

    assign crc_word  = crc_step(a, b, c, 16);
    assign crc_byte  = crc_step(a, b, c, 8);
    assign sig_a     = sig_bits(a);
    assign sig_neg_a = sig_bits(16'd0 - a);
endmodule

// ===== hdl/eod_core.sv
// instruction decoder and executor for the added secondary operations
`timescale 1ns/100ps
`include "eod_regs.svh"
module eod_core
    import eod_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // instruction byte stream
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    output logic             byte_ready,
    // process priority, high when running at low priority
    input  wire logic        pri_low,
    // evaluation stack and pointers
    output eod_word_t        areg_r,
    output eod_word_t        breg_r,
    output eod_word_t        creg_r,
    output eod_word_t        iptr_r,
    output eod_word_t        wptr_r,
    // status
    output logic             break_en_r,
    output logic             timer_en_hi_r,
    output logic             timer_en_lo_r,
    output logic             desched_ok_r,
    output logic             unknown_op_r,
    // memory port for the saved pointer pair
    output logic             mem_rd_r,
    output logic             mem_wr_r,
    output eod_word_t        mem_addr_r,
    output eod_word_t        mem_wdata_r,
    input  wire eod_word_t   mem_rdata
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    eod_state_t  state_r;
    eod_word_t   oper_r;
    eod_word_t   oper_nxt;
    eod_word_t   new_iptr_r;
    eod_word_t   new_wptr_r;
    logic        take;
    logic        is_prefix;
    logic        is_operate;
    logic        is_jump;
    logic        swap_go;
    logic        known;
    logic        tmr_load;
    logic [5:0]  cyc_nxt;
    logic [5:0]  remain;
    logic        busy;
    eod_word_t   cnt_sum;
    eod_word_t   rev_word;
    eod_word_t   rev_nbits;
    eod_word_t   crc_word;
    eod_word_t   crc_byte;
    logic [4:0]  sig_a;
    logic [4:0]  sig_neg_a;
    logic [4:0]  nbits;

    // ----------------------------------------
    // byte acceptance
    // ----------------------------------------
    assign byte_ready = !busy && (state_r == EOD_ST_IDLE);
    assign take       = byte_valid && byte_ready;
    assign is_prefix  = (byte_data[7:4] == `EOD_NIB_PREFIX);
    assign is_operate = (byte_data[7:4] == `EOD_NIB_OPERATE);
    assign is_jump    = (byte_data[7:4] == `EOD_NIB_JUMP);
    assign oper_nxt   = {oper_r[11:0], byte_data[3:0]};
    assign nbits      = (areg_r >= 16'd16) ? 5'd16 : {1'b0, areg_r[3:0]};

    // jump-zero with breakpoints on, or explicit break
    assign swap_go = take && ((is_jump && oper_nxt == `EOD_WORD_ZERO && break_en_r)
                              || (is_operate && oper_nxt == `EOD_OP_BREAK));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    eod_cycle_timer eod_cycle_timer_inst (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .cycles   (cyc_nxt),
        .remain   (remain),
        .busy     (busy)
    );

    eod_bit_unit eod_bit_unit_inst (
        .a         (areg_r),
        .b         (breg_r),
        .c         (creg_r),
        .cnt_sum   (cnt_sum),
        .rev_word  (rev_word),
        .rev_nbits (rev_nbits),
        .crc_word  (crc_word),
        .crc_byte  (crc_byte),
        .sig_a     (sig_a),
        .sig_neg_a (sig_neg_a)
    );

    // ----------------------------------------
    // cycle count of the accepted instruction
    // ----------------------------------------
    always_comb begin
        cyc_nxt = `EOD_CYC_ONE;
        known   = 1'b1;
        if (is_jump) begin
            if (oper_nxt != `EOD_WORD_ZERO) begin
                cyc_nxt = `EOD_CYC_ONE;
            end else if (!break_en_r) begin
                cyc_nxt = `EOD_CYC_J0_PLAIN;
            end else begin
                cyc_nxt = pri_low ? `EOD_CYC_J0_LO : `EOD_CYC_J0_HI;
            end
        end else if (is_operate) begin
            case (oper_nxt)
                `EOD_OP_BREAK:      cyc_nxt = pri_low ? `EOD_CYC_BRK_LO
                                                      : `EOD_CYC_BRK_HI;
                `EOD_OP_BRK_SET:    cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_BRK_CLR:    cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_BRK_QUERY:  cyc_nxt = `EOD_CYC_QUERY;
                `EOD_OP_PROD: begin
                    if (areg_r[15]) begin
                        cyc_nxt = {1'b0, sig_neg_a} + `EOD_CYC_PROD_NEG;
                    end else begin
                        cyc_nxt = {1'b0, sig_a} + `EOD_CYC_PROD_POS;
                    end
                end
                `EOD_OP_DUP:        cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_POP:        cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_CRCWORD:    cyc_nxt = `EOD_CYC_CRCWORD;
                `EOD_OP_CRCBYTE:    cyc_nxt = `EOD_CYC_CRCBYTE;
                `EOD_OP_BITCNT:     cyc_nxt = {1'b0, sig_a} + `EOD_CYC_BITCNT;
                `EOD_OP_REVWORD:    cyc_nxt = `EOD_CYC_REVWORD;
                `EOD_OP_REVNBITS:   cyc_nxt = {1'b0, nbits} + `EOD_CYC_REVNBITS;
                `EOD_OP_MEMSTART:   cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_DEVID:      cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_TMR_DIS_HI: cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_TMR_DIS_LO: cyc_nxt = `EOD_CYC_ONE;
                `EOD_OP_TMR_EN_HI:  cyc_nxt = `EOD_CYC_TMR_EN;
                `EOD_OP_TMR_EN_LO:  cyc_nxt = `EOD_CYC_TMR_EN;
                default: begin
                    cyc_nxt = `EOD_CYC_ONE;
                    known   = 1'b0;
                end
            endcase
        end else if (!is_prefix) begin
            known = 1'b0;
        end
    end

    assign tmr_load = take && !is_prefix;

    // ----------------------------------------
    // operand accumulation
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            oper_r <= `EOD_WORD_ZERO;
        end else if (take) begin
            oper_r <= is_prefix ? oper_nxt : `EOD_WORD_ZERO;
        end
    end

    // ----------------------------------------
    // evaluation stack
    // ----------------------------------------
    // a jump-zero swap takes no branch here and an explicit break takes only the holding default, so the stack is preserved
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            areg_r <= `EOD_WORD_ZERO;
            breg_r <= `EOD_WORD_ZERO;
            creg_r <= `EOD_WORD_ZERO;
        end else if (take && is_operate) begin
            case (oper_nxt)
                `EOD_OP_PROD: begin
                    areg_r <= 16'(areg_r * breg_r);
                    breg_r <= creg_r;
                end
                `EOD_OP_DUP: begin
                    breg_r <= areg_r;
                    creg_r <= breg_r;
                end
                `EOD_OP_POP: begin
                    areg_r <= breg_r;
                    breg_r <= creg_r;
                end
                `EOD_OP_CRCWORD: begin
                    areg_r <= crc_word;
                    breg_r <= creg_r;
                end
                `EOD_OP_CRCBYTE: begin
                    areg_r <= crc_byte;
                    breg_r <= creg_r;
                end
                `EOD_OP_BITCNT: begin
                    areg_r <= cnt_sum;
                    breg_r <= creg_r;
                end
                `EOD_OP_REVWORD: begin
                    areg_r <= rev_word;
                end
                `EOD_OP_REVNBITS: begin
                    areg_r <= rev_nbits;
                    breg_r <= creg_r;
                end
                `EOD_OP_BRK_QUERY: begin
                    areg_r <= break_en_r ? `EOD_WORD_TRUE : `EOD_WORD_ZERO;
                    breg_r <= areg_r;
                    creg_r <= breg_r;
                end
                `EOD_OP_MEMSTART: begin
                    areg_r <= `EOD_MEMSTART;
                    breg_r <= areg_r;
                    creg_r <= breg_r;
                end
                `EOD_OP_DEVID: begin
                    areg_r <= `EOD_DEVICE_ID;
                    breg_r <= areg_r;
                    creg_r <= breg_r;
                end
                default: begin
                    areg_r <= areg_r;
                end
            endcase
        end
    end

    // ----------------------------------------
    // flags
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            break_en_r <= 1'b0;
        end else if (take && is_operate && oper_nxt == `EOD_OP_BRK_SET) begin
            break_en_r <= 1'b1;
        end else if (take && is_operate && oper_nxt == `EOD_OP_BRK_CLR) begin
            break_en_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_en_hi_r <= 1'b0;
            timer_en_lo_r <= 1'b0;
        end else if (take && is_operate) begin
            if (oper_nxt == `EOD_OP_TMR_DIS_HI) begin
                timer_en_hi_r <= 1'b0;
            end
            if (oper_nxt == `EOD_OP_TMR_DIS_LO) begin
                timer_en_lo_r <= 1'b0;
            end
            if (oper_nxt == `EOD_OP_TMR_EN_HI) begin
                timer_en_hi_r <= 1'b1;
            end
            if (oper_nxt == `EOD_OP_TMR_EN_LO) begin
                timer_en_lo_r <= 1'b1;
            end
        end
    end

    // plain jump-zero offers a descheduling point; a swap never does
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            desched_ok_r <= 1'b0;
            unknown_op_r <= 1'b0;
        end else begin
            desched_ok_r <= take && is_jump && oper_nxt == `EOD_WORD_ZERO
                            && !break_en_r;
            unknown_op_r <= take && !known;
        end
    end

    // ----------------------------------------
    // pointer swap sequence
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_r     <= EOD_ST_IDLE;
            mem_rd_r    <= 1'b0;
            mem_wr_r    <= 1'b0;
            mem_addr_r  <= `EOD_WORD_ZERO;
            mem_wdata_r <= `EOD_WORD_ZERO;
            new_iptr_r  <= `EOD_WORD_ZERO;
            new_wptr_r  <= `EOD_WORD_ZERO;
        end else begin
            case (state_r)
                EOD_ST_IDLE: begin
                    if (swap_go) begin
                        state_r    <= EOD_ST_RD_I;
                        mem_rd_r   <= 1'b1;
                        mem_addr_r <= `EOD_MEMSTART + `EOD_SAVE_IPTR_OFS;
                    end
                end
                EOD_ST_RD_I: begin
                    state_r    <= EOD_ST_RD_W;
                    mem_addr_r <= `EOD_MEMSTART + `EOD_SAVE_WPTR_OFS;
                end
                EOD_ST_RD_W: begin
                    state_r     <= EOD_ST_WR_I;
                    new_iptr_r  <= mem_rdata;
                    mem_rd_r    <= 1'b0;
                    mem_wr_r    <= 1'b1;
                    mem_addr_r  <= `EOD_MEMSTART + `EOD_SAVE_IPTR_OFS;
                    mem_wdata_r <= iptr_r;
                end
                EOD_ST_WR_I: begin
                    state_r     <= EOD_ST_WR_W;
                    new_wptr_r  <= mem_rdata;
                    mem_addr_r  <= `EOD_MEMSTART + `EOD_SAVE_WPTR_OFS;
                    mem_wdata_r <= wptr_r;
                end
                EOD_ST_WR_W: begin
                    state_r  <= EOD_ST_WAIT;
                    mem_wr_r <= 1'b0;
                end
                EOD_ST_WAIT: begin
                    if (remain == 6'd1) begin
                        state_r <= EOD_ST_IDLE;
                    end
                end
                default: begin
                    state_r  <= EOD_ST_IDLE;
                    mem_rd_r <= 1'b0;
                    mem_wr_r <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // instruction and workspace pointers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            iptr_r <= `EOD_IPTR_RST;
            wptr_r <= `EOD_WPTR_RST;
        end else if (state_r == EOD_ST_WAIT && remain == 6'd1) begin
            iptr_r <= new_iptr_r;
            wptr_r <= new_wptr_r;
        end else if (take) begin
            if (is_jump && !swap_go) begin
                iptr_r <= iptr_r + 16'd1 + oper_nxt;
            end else begin
                iptr_r <= iptr_r + 16'd1;
            end
        end
    end

    // core_clk is the multiplied processor clock of `EOD_CORE_KHZ kHz
endmodule

// ===== verification/eod_core_props.sv
// assertion checker for the extended opcode decoder
`timescale 1ns/100ps
module eod_core_props
    import eod_pkg::*;
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst_n,
    // byte stream
    input wire logic       byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic       byte_ready,
    input wire logic       pri_low,
    // state and memory port
    input wire eod_word_t  areg_r,
    input wire eod_word_t  breg_r,
    input wire logic       break_en_r,
    input wire logic       desched_ok_r,
    input wire logic       mem_rd_r,
    input wire logic       mem_wr_r,
    input wire eod_word_t  mem_addr_r,
    input wire eod_word_t  mem_wdata_r,
    input wire eod_word_t  iptr_r,
    input wire eod_word_t  wptr_r
);
    logic [7:0] last_r;
    logic       acc;
    logic       jz;
    assign acc = byte_valid && byte_ready;
    // jump byte with no prefix in front, so the offset is zero
    assign jz = acc && byte_data == 8'h00 && last_r[7:4] != 4'h2;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_r <= 8'h00;
        end else if (acc) begin
            last_r <= byte_data;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_jump_plain: assert property (jz && !break_en_r |=>
        desched_ok_r && !byte_ready ##1 !byte_ready ##1 byte_ready) else $error("plain jump");
    a_swap_hi_len: assert property (jz && break_en_r && !pri_low |=>
        (!byte_ready)[*8] ##1 (!byte_ready)[*2] ##1 byte_ready) else $error("swap hi length");
    a_swap_lo_len: assert property (jz && break_en_r && pri_low |=>
        (!byte_ready)[*8] ##1 (!byte_ready)[*4] ##1 byte_ready) else $error("swap lo length");
    a_swap_quiet: assert property (jz && break_en_r |=>
        (!desched_ok_r && $stable(areg_r) && $stable(breg_r))[*8]) else $error("swap stack");
    a_swap_mem: assert property (jz && break_en_r |=> mem_rd_r && mem_addr_r == 16'h004a
        ##1 mem_rd_r && mem_addr_r == 16'h004c ##1 mem_wr_r && mem_addr_r == 16'h004a)
        else $error("swap memory order");
    a_swap_wdata: assert property (jz && break_en_r |=> ##2
        mem_wr_r && mem_wdata_r == iptr_r ##1 mem_wr_r && mem_wdata_r == wptr_r)
        else $error("swap write data");
    a_flag_set: assert property (acc && last_r == 8'h2b && byte_data == 8'hf3 |=>
        break_en_r && byte_ready) else $error("flag set");
    a_flag_clear: assert property (acc && last_r == 8'h2b && byte_data == 8'hf2 |=>
        !break_en_r && byte_ready) else $error("flag clear");
    a_flag_query: assert property (acc && last_r == 8'h2b && byte_data == 8'hf4 |=>
        areg_r == {15'h0000, $past(break_en_r)} && !byte_ready ##1 byte_ready)
        else $error("flag query");
    a_prefix_ready: assert property (acc && byte_data[7:4] == 4'h2 |=> byte_ready)
        else $error("prefix stall");
    a_memstart_push: assert property (acc && last_r == 8'h27 && byte_data == 8'hfe |=>
        areg_r == 16'h0048 && byte_ready) else $error("memstart push");
    c_swap: cover property (jz && break_en_r);
    c_plain: cover property (jz && !break_en_r);
    c_query: cover property (acc && last_r == 8'h2b && byte_data == 8'hf4);
endmodule

bind eod_core eod_core_props eod_core_props_inst (.core_clk, .rst_n, .byte_valid, .byte_data,
    .byte_ready, .pri_low, .areg_r, .breg_r, .break_en_r, .desched_ok_r, .mem_rd_r, .mem_wr_r,
    .mem_addr_r, .mem_wdata_r, .iptr_r, .wptr_r);

// ===== verification/eod_core_test.sv
// self-checking bench for the extended opcode decoder
`timescale 1ns/100ps
`include "eod_regs.svh"
module eod_core_test
    import eod_pkg::*;
;
    logic       core_clk = 1'b0;
    logic       rst_n;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       byte_ready;
    logic       pri_low;
    eod_word_t  areg_r, breg_r, creg_r, iptr_r, wptr_r;
    eod_word_t  mem_addr_r, mem_wdata_r, mem_rdata;
    logic       break_en_r, timer_en_hi_r, timer_en_lo_r;
    logic       desched_ok_r, unknown_op_r, mem_rd_r, mem_wr_r;
    int         n_mismatch;
    int         n_compared;
    eod_word_t  a;
    localparam eod_word_t SAV_I = 16'h0300;
    localparam eod_word_t SAV_W = 16'h0500;

    eod_core eod_core_inst (.core_clk, .rst_n, .byte_valid, .byte_data, .byte_ready, .pri_low,
        .areg_r, .breg_r, .creg_r, .iptr_r, .wptr_r, .break_en_r, .timer_en_hi_r,
        .timer_en_lo_r, .desched_ok_r, .unknown_op_r, .mem_rd_r, .mem_wr_r, .mem_addr_r,
        .mem_wdata_r, .mem_rdata);

    always #25 core_clk = ~core_clk;
    // saved pointer pair, answered one cycle after the address
    always @(posedge core_clk) mem_rdata <= (mem_addr_r == 16'h004a) ? SAV_I : SAV_W;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // offer one byte, then count the cycles that ready stays low
    task automatic op(input logic [7:0] b, input int n);
        int k;
        k = 0;
        byte_valid = 1'b1;
        byte_data = b;
        @(negedge core_clk);
        // valid stays up across back-to-back one-cycle bytes
        if (byte_ready !== 1'b1) begin
            byte_valid = 1'b0;
        end
        while (byte_ready !== 1'b1 && k < 60) begin
            k++;
            @(negedge core_clk);
        end
        chk(16'(k), 16'(n - 1));
        if (k == 60) begin
            conclude();
        end
    endtask

    task automatic op2(input logic [7:0] p, input logic [7:0] o, input int n);
        op(p, 1);
        op(o, n);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(areg_r, 16'h0000);
        chk(wptr_r, 16'h0100);
        chk({break_en_r, timer_en_hi_r, timer_en_lo_r, byte_ready}, 4'h1);
    endtask

    task automatic t_flags;
        op2(8'h2b, 8'hf3, 1);
        chk(break_en_r, 1'b1);
        op2(8'h2b, 8'hf4, 2);
        chk(areg_r, 16'h0001);
        op2(8'h2b, 8'hf2, 1);
        op2(8'h2b, 8'hf4, 2);
        chk(areg_r, 16'h0000);
    endtask

    task automatic t_stack;
        op2(8'h27, 8'hfe, 1);
        chk(areg_r, `EOD_MEMSTART);
        op2(8'h25, 8'hfa, 1);
        chk(breg_r, `EOD_MEMSTART);
        op2(8'h27, 8'hf9, 1);
        chk(breg_r, 16'h0000);
        op(8'h21, 1);
        op2(8'h27, 8'hfc, 1);
        chk(areg_r, `EOD_DEVICE_ID);
    endtask

    task automatic t_timers;
        op(8'h30, 1);
        chk(unknown_op_r, 1'b1);
        op2(8'h27, 8'hfc, 6);
        op2(8'h27, 8'hfd, 6);
        chk({timer_en_hi_r, timer_en_lo_r}, 2'h3);
        op2(8'h27, 8'hfa, 1);
        chk({timer_en_hi_r, timer_en_lo_r}, 2'h1);
        op2(8'h27, 8'hfb, 1);
        chk({timer_en_hi_r, timer_en_lo_r}, 2'h0);
    endtask

    task automatic t_swap;
        a = wptr_r;
        op(8'h00, 3);
        chk(wptr_r, a);
        op2(8'h2b, 8'hf3, 1);
        a = areg_r;
        op(8'h00, 11);
        chk(iptr_r, SAV_I);
        chk(wptr_r, SAV_W);
        chk(areg_r, a);
        pri_low = 1'b1;
        op(8'h00, 13);
        op2(8'h2b, 8'hf1, 11);
        pri_low = 1'b0;
        op2(8'h2b, 8'hf1, 9);
        op2(8'h2b, 8'hf2, 1);
    endtask

    task automatic t_bits;
        op2(8'h27, 8'hfe, 1);
        chk(creg_r, `EOD_MEMSTART);
        op2(8'h27, 8'hf7, 36);
        chk(areg_r, 16'h1200);
        op2(8'h27, 8'hf4, 35);
        chk(areg_r, 16'h1127);
        op2(8'h27, 8'hf5, 11);
        chk(areg_r, 16'h23c8);
        op2(8'h27, 8'hfe, 1);
        op2(8'h27, 8'hf6, 9);
        chk(areg_r, 16'h23ca);
        op2(8'h27, 8'hfe, 1);
        op(8'hf8, 11);
        chk(areg_r, 16'h10d0);
        op2(8'h27, 8'hfe, 1);
        op2(8'h27, 8'hf8, 20);
        chk(areg_r, 16'h1200);
    endtask

    initial begin
        rst_n = 1'b0;
        byte_valid = 1'b0;
        byte_data = 8'h00;
        pri_low = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        t_reset();
        t_flags();
        t_stack();
        t_timers();
        t_swap();
        t_bits();
        conclude();
    end
endmodule
